// File: tb/msgbuf_status_sva.sv
`timescale 1ns/1ps
module msgbuf_status_sva
  import msgbuf_status_pkg::*;
#(
  parameter int unsigned NUM_BUFFERS = 64,
  parameter int unsigned COUNT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slot_end_a,
  input wire logic syntax_error_a,
  input wire logic content_error_a,
  input wire logic boundary_error_a,
  input wire logic tx_conflict_a,
  input wire logic slot_end_b,
  input wire logic syntax_error_b,
  input wire logic content_error_b,
  input wire logic boundary_error_b,
  input wire logic tx_conflict_b,
  input wire logic [1:0] fault_mode_field,
  input wire logic [1:0] slot_policy_field,
  input wire logic [2:0] poc_state_field,
  input wire logic [3:0] boot_substate_field,
  input wire logic [2:0] wake_outcome_field,
  input wire logic [COUNT_WIDTH-1:0] chan_a_error_count,
  input wire logic [COUNT_WIDTH-1:0] chan_b_error_count,
  input wire logic [REG_WIDTH-1:0] protocol_status_0,
  input wire logic engine_halted,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic ea = slot_end_a && (syntax_error_a || content_error_a ||
    boundary_error_a || tx_conflict_a);
  wire logic eb = slot_end_b && (syntax_error_b || content_error_b ||
    boundary_error_b || tx_conflict_b);
  wire logic [15:0] st = {fault_mode_field, slot_policy_field, 1'h0,
    poc_state_field, boot_substate_field, 1'h0, wake_outcome_field};
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rx; s_axi_rvalid && s_axi_rready; endsequence
  property p_ia; ea |=> chan_a_error_count ==
    COUNT_WIDTH'($past(chan_a_error_count) + 1); endproperty
  property p_ha; !ea |=> $stable(chan_a_error_count); endproperty
  property p_ib; eb |=> chan_b_error_count ==
    COUNT_WIDTH'($past(chan_b_error_count) + 1); endproperty
  property p_hb; !eb |=> $stable(chan_b_error_count); endproperty
  property p_st; !$past(sys_rst) |-> protocol_status_0 == $past(st);
  endproperty
  property p_hl; !$past(sys_rst) |->
    engine_halted == ($past(poc_state_field) == POC_HALT); endproperty
  property p_rl; s_ar |=> s_axi_rvalid; endproperty
  property p_rh; s_rx |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_ia: assert property (p_ia)
    else $error("channel A count did not step by one");
  a_ha: assert property (p_ha)
    else $error("channel A count moved without an error slot");
  a_ib: assert property (p_ib)
    else $error("channel B count did not step by one");
  a_hb: assert property (p_hb)
    else $error("channel B count moved without an error slot");
  a_st: assert property (p_st)
    else $error("status word does not match engine state");
  a_hl: assert property (p_hl)
    else $error("halt flag disagrees with state field");
  a_rl: assert property (p_rl)
    else $error("read answer late");
  a_rh: assert property (p_rh)
    else $error("read answer not released");
endmodule

// File: tb/msgbuf_vector_and_protocol_status_test.sv
`timescale 1ns/1ps
module msgbuf_vector_and_protocol_status_test;
  import msgbuf_status_pkg::*;
  logic clock = 1'h0, sys_rst = 1'h1;
  logic [63:0] buffer_irq_flag = '0, buffer_irq_enable = '0, buffer_is_tx = '0;
  logic run_a = 1'h0, run_b = 1'h0;
  logic [3:0] err_a = 4'h0, err_b = 4'h0;
  wire logic slot_end_a, syntax_error_a, content_error_a, boundary_error_a;
  wire logic tx_conflict_a, slot_end_b, syntax_error_b, content_error_b;
  wire logic boundary_error_b, tx_conflict_b, engine_halted;
  logic [1:0] fault_mode_field = 2'h0, slot_policy_field = 2'h0;
  logic [2:0] poc_state_field = 3'h0, wake_outcome_field = 3'h0;
  logic [3:0] boot_substate_field = 4'h0;
  wire logic [6:0] tx_vector_field, rx_vector_field;
  wire logic [15:0] chan_a_error_count, chan_b_error_count, protocol_status_0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'hFFFFFFFF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] addrs [4] = '{OFFSET_VECTOR, OFFSET_CHAN_A, OFFSET_CHAN_B,
    OFFSET_PROTOCOL};
  int miscompares = 0, cmp_count = 0;
  slot_engine_model eng_a (.run(run_a), .err(err_a), .slot_end(slot_end_a),
    .ind({syntax_error_a, content_error_a, boundary_error_a, tx_conflict_a}));
  slot_engine_model eng_b (.run(run_b), .err(err_b), .slot_end(slot_end_b),
    .ind({syntax_error_b, content_error_b, boundary_error_b, tx_conflict_b}));
  msgbuf_vector_and_protocol_status #(.NUM_BUFFERS(64), .COUNT_WIDTH(16)) dut (
    .clock, .sys_rst, .buffer_irq_flag, .buffer_irq_enable, .buffer_is_tx,
    .slot_end_a, .syntax_error_a, .content_error_a, .boundary_error_a,
    .tx_conflict_a, .slot_end_b, .syntax_error_b, .content_error_b,
    .boundary_error_b, .tx_conflict_b, .fault_mode_field, .slot_policy_field,
    .poc_state_field, .boot_substate_field, .wake_outcome_field,
    .tx_vector_field, .rx_vector_field, .chan_a_error_count,
    .chan_b_error_count, .protocol_status_0, .engine_halted, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clock); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge clock); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clock); while (s_axi_wready !== 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge clock); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(addrs[i]);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
    end
  endtask
  task automatic vec(input logic [63:0] f, e, t, input logic [15:0] x);
    @(posedge clock);
    buffer_irq_flag <= f;
    buffer_irq_enable <= e;
    buffer_is_tx <= t;
    rd(OFFSET_VECTOR);
    chk(d, {16'h0, x});
    chk({17'h0, tx_vector_field, 1'h0, rx_vector_field}, {16'h0, x});
  endtask
  task automatic pulse(input logic b, input logic [3:0] e, input int n);
    @(posedge clock);
    if (b) begin
      run_b <= 1'h1;
      err_b <= e;
    end else begin
      run_a <= 1'h1;
      err_a <= e;
    end
    repeat (n) @(posedge clock);
    run_a <= 1'h0;
    run_b <= 1'h0;
  endtask
  task automatic t_cnt;
    for (int i = 0; i < 4; i++) pulse(1'h0, 4'h1 << i, 1);
    pulse(1'h0, 4'h0, 3);
    pulse(1'h1, 4'h9, 1);
    rd(OFFSET_CHAN_A);
    chk(d, 32'h4);
    rd(OFFSET_CHAN_B);
    chk(d, 32'h1);
    pulse(1'h0, 4'hF, 65532);
    rd(OFFSET_CHAN_A);
    chk(d, 32'h0);
  endtask
  task automatic t_stat;
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      fault_mode_field <= i[1:0];
      slot_policy_field <= i[2:1];
      poc_state_field <= i[2:0];
      boot_substate_field <= i[3:0];
      wake_outcome_field <= i[2:0];
      rd(OFFSET_PROTOCOL);
      chk(d, {16'h0, i[1:0], i[2:1], 1'h0, i[2:0], i[3:0], 1'h0,
        i[2:0]});
      chk({31'h0, engine_halted}, {31'h0, i == 6});
    end
  endtask
  task automatic t_wr;
    wr(OFFSET_PROTOCOL);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFFSET_PROTOCOL);
    chk(d, 32'h80);
    wr(OFFSET_CHAN_B);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFFSET_CHAN_B);
    chk(d, 32'h1);
    wr(8'h30);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h30);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
  endtask
  initial begin
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'h0;
    t_reset;
    vec('0, '0, '0, 16'h0);
    vec(64'h0000_0100_0000_022E, 64'h0000_0100_0000_0228,
      64'h0000_0000_0000_0222, 16'h0503);
    vec(64'h8000_0000_0000_0001, 64'h8000_0000_0000_0001,
      64'h8000_0000_0000_0000, 16'h3F00);
    t_cnt;
    t_stat;
    t_wr;
    stop_test;
  end
endmodule
bind msgbuf_vector_and_protocol_status msgbuf_status_sva #(
  .NUM_BUFFERS(NUM_BUFFERS), .COUNT_WIDTH(COUNT_WIDTH)) u_sva (
  .clock, .sys_rst, .slot_end_a, .syntax_error_a, .content_error_a,
  .boundary_error_a, .tx_conflict_a, .slot_end_b, .syntax_error_b,
  .content_error_b, .boundary_error_b, .tx_conflict_b, .fault_mode_field,
  .slot_policy_field, .poc_state_field, .boot_substate_field,
  .wake_outcome_field, .chan_a_error_count, .chan_b_error_count,
  .protocol_status_0, .engine_halted, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);

// File: tb/slot_engine_model.sv
`timescale 1ns/1ps
module slot_engine_model (
  input wire logic run,
  input wire logic [3:0] err,
  output logic slot_end,
  output logic [3:0] ind
);
  // One evaluated slot closes per cycle while run is high
  assign slot_end = run;
  // Indicators are meaningless between slots, so show the inverse
  assign ind = run ? err : ~err;
endmodule

// File: verilog/msgbuf_status_pkg.sv
package msgbuf_status_pkg;

  // Register bus geometry
  localparam int unsigned AXI_ADDR_WIDTH = 8;
  localparam int unsigned AXI_DATA_WIDTH = 32;
  localparam int unsigned REG_WIDTH = 16;

  // Register byte offsets
  localparam logic [7:0] OFFSET_VECTOR = 8'h10;
  localparam logic [7:0] OFFSET_CHAN_A = 8'h14;
  localparam logic [7:0] OFFSET_CHAN_B = 8'h18;
  localparam logic [7:0] OFFSET_PROTOCOL = 8'h28;

  // Reset values
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PROTOCOL_RESET = 16'h0000;

  // Vector register layout
  localparam int unsigned VEC_WIDTH = 7;
  localparam int unsigned TX_VEC_LSB = 8;
  localparam int unsigned RX_VEC_LSB = 0;

  // Protocol status layout
  localparam int unsigned FAULT_LSB = 14;
  localparam int unsigned SLOT_LSB = 12;
  localparam int unsigned POC_LSB = 8;
  localparam int unsigned BOOT_LSB = 4;
  localparam int unsigned WAKE_LSB = 0;
  localparam logic [15:0] PROTOCOL_MASK = 16'hF7F7;

  // Field codes
  localparam logic [1:0] FAULT_ACTIVE = 2'h0;
  localparam logic [1:0] FAULT_PASSIVE = 2'h1;
  localparam logic [1:0] FAULT_COMM_HALT = 2'h2;
  localparam logic [1:0] SLOT_SINGLE = 2'h0;
  localparam logic [1:0] SLOT_ALL_PENDING = 2'h1;
  localparam logic [1:0] SLOT_ALL = 2'h2;
  localparam logic [2:0] POC_DEFAULT_CONFIG = 3'h0;
  localparam logic [2:0] POC_CONFIG = 3'h1;
  localparam logic [2:0] POC_WAKEUP = 3'h2;
  localparam logic [2:0] POC_READY = 3'h3;
  localparam logic [2:0] POC_NORMAL_PASSIVE = 3'h4;
  localparam logic [2:0] POC_NORMAL_ACTIVE = 3'h5;
  localparam logic [2:0] POC_HALT = 3'h6;
  localparam logic [2:0] POC_STARTUP = 3'h7;
  localparam logic [3:0] BOOT_COLD_COLLISION = 4'h2;
  localparam logic [3:0] BOOT_COLD_LISTEN = 4'h3;
  localparam logic [3:0] BOOT_INTEG_CONSISTENCY = 4'h4;
  localparam logic [3:0] BOOT_INTEG_LISTEN = 4'h5;
  localparam logic [3:0] BOOT_INIT_SCHEDULE = 4'h7;
  localparam logic [2:0] WAKE_RX_HEADER = 3'h1;
  localparam logic [2:0] WAKE_RX_WAKEUP = 3'h2;
  localparam logic [2:0] WAKE_COLL_HEADER = 3'h3;
  localparam logic [2:0] WAKE_COLL_WAKEUP = 3'h4;
  localparam logic [2:0] WAKE_COLL_UNKNOWN = 3'h5;
  localparam logic [2:0] WAKE_TRANSMITTED = 3'h6;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: verilog/msgbuf_vector_and_protocol_status.sv
`timescale 1ns/1ps
module msgbuf_vector_and_protocol_status
  import msgbuf_status_pkg::*;
#(
  parameter int unsigned NUM_BUFFERS = 64,
  parameter int unsigned COUNT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  // Per-buffer interrupt state
  input wire logic [NUM_BUFFERS-1:0] buffer_irq_flag,
  input wire logic [NUM_BUFFERS-1:0] buffer_irq_enable,
  input wire logic [NUM_BUFFERS-1:0] buffer_is_tx,
  // Slot status, channel A
  input wire logic slot_end_a,
  input wire logic syntax_error_a,
  input wire logic content_error_a,
  input wire logic boundary_error_a,
  input wire logic tx_conflict_a,
  // Slot status, channel B
  input wire logic slot_end_b,
  input wire logic syntax_error_b,
  input wire logic content_error_b,
  input wire logic boundary_error_b,
  input wire logic tx_conflict_b,
  // Protocol engine state
  input wire logic [1:0] fault_mode_field,
  input wire logic [1:0] slot_policy_field,
  input wire logic [2:0] poc_state_field,
  input wire logic [3:0] boot_substate_field,
  input wire logic [2:0] wake_outcome_field,
  // Registered results for neighbouring logic
  output logic [VEC_WIDTH-1:0] tx_vector_field,
  output logic [VEC_WIDTH-1:0] rx_vector_field,
  output logic [COUNT_WIDTH-1:0] chan_a_error_count,
  output logic [COUNT_WIDTH-1:0] chan_b_error_count,
  output logic [REG_WIDTH-1:0] protocol_status_0,
  output logic engine_halted,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_WIDTH-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_WIDTH-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {
    READ_IDLE = 2'b01,
    READ_ANSWER = 2'b10
  } read_state_type;

  typedef enum logic [1:0] {
    WRITE_COLLECT = 2'b01,
    WRITE_ANSWER = 2'b10
  } write_state_type;

  typedef struct packed {
    read_state_type read_state;
    write_state_type write_state;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_WIDTH-1:0] aw_addr;
    logic [1:0] bresp;
    logic [AXI_DATA_WIDTH-1:0] rdata;
    logic [1:0] rresp;
    logic [VEC_WIDTH-1:0] tx_vector;
    logic [VEC_WIDTH-1:0] rx_vector;
    logic [REG_WIDTH-1:0] protocol_status;
  } state_type;

  state_type state;
  state_type next_state;
  logic [COUNT_WIDTH-1:0] count_a;
  logic [COUNT_WIDTH-1:0] count_b;
  logic [NUM_BUFFERS-1:0] pending;
  logic [NUM_BUFFERS-1:0] tx_pending;
  logic [NUM_BUFFERS-1:0] rx_pending;

  // Fixed priority: the lowest set index, zero when none is set
  function automatic logic [VEC_WIDTH-1:0] lowest_buffer(
    input logic [NUM_BUFFERS-1:0] request
  );
    logic [VEC_WIDTH-1:0] index;
    index = '0;
    for (int i = int'(NUM_BUFFERS) - 1; i >= 0; i--) begin
      if (request[i]) begin
        index = VEC_WIDTH'(i);
      end
    end
    return index;
  endfunction

  // Byte lane bits are ignored: each register is one aligned word
  function automatic logic [7:0] word_of(
    input logic [AXI_ADDR_WIDTH-1:0] addr
  );
    return {addr[7:2], 2'b00};
  endfunction

  // Word-aligned decode shared by the read and write paths
  function automatic logic is_mapped(
    input logic [AXI_ADDR_WIDTH-1:0] addr
  );
    logic [7:0] word;
    word = word_of(addr);
    return (word == OFFSET_VECTOR) || (word == OFFSET_CHAN_A) ||
      (word == OFFSET_CHAN_B) || (word == OFFSET_PROTOCOL);
  endfunction

  function automatic logic [REG_WIDTH-1:0] reg_value(
    input logic [AXI_ADDR_WIDTH-1:0] addr,
    input state_type current,
    input logic [COUNT_WIDTH-1:0] tally_a,
    input logic [COUNT_WIDTH-1:0] tally_b
  );
    logic [7:0] word;
    logic [REG_WIDTH-1:0] value;
    word = word_of(addr);
    value = '0;
    if (word == OFFSET_VECTOR) begin
      value[TX_VEC_LSB +: VEC_WIDTH] = current.tx_vector;
      value[RX_VEC_LSB +: VEC_WIDTH] = current.rx_vector;
    end else if (word == OFFSET_CHAN_A) begin
      value = REG_WIDTH'(tally_a);
    end else if (word == OFFSET_CHAN_B) begin
      value = REG_WIDTH'(tally_b);
    end else if (word == OFFSET_PROTOCOL) begin
      value = current.protocol_status;
    end
    return value;
  endfunction

  // Reserved codes pass through unchanged; the unused bits stay clear
  function automatic logic [REG_WIDTH-1:0] pack_status(
    input logic [1:0] fault,
    input logic [1:0] slot,
    input logic [2:0] poc,
    input logic [3:0] boot,
    input logic [2:0] wake
  );
    logic [REG_WIDTH-1:0] status;
    status = '0;
    status[FAULT_LSB +: 2] = fault;
    status[SLOT_LSB +: 2] = slot;
    status[POC_LSB +: 3] = poc;
    status[BOOT_LSB +: 4] = boot;
    status[WAKE_LSB +: 3] = wake;
    return status & PROTOCOL_MASK;
  endfunction

  assign pending = buffer_irq_flag & buffer_irq_enable;
  assign tx_pending = pending & buffer_is_tx;
  assign rx_pending = pending & ~buffer_is_tx;

  slot_error_counter #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) counter_a (
    .clock(clock),
    .sys_rst(sys_rst),
    .slot_end(slot_end_a),
    .syntax_error(syntax_error_a),
    .content_error(content_error_a),
    .boundary_error(boundary_error_a),
    .tx_conflict(tx_conflict_a),
    .count(count_a)
  );

  slot_error_counter #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) counter_b (
    .clock(clock),
    .sys_rst(sys_rst),
    .slot_end(slot_end_b),
    .syntax_error(syntax_error_b),
    .content_error(content_error_b),
    .boundary_error(boundary_error_b),
    .tx_conflict(tx_conflict_b),
    .count(count_b)
  );

  always_comb begin
    next_state = state;

    // Vectors follow the buffer flags one cycle later
    next_state.tx_vector = lowest_buffer(tx_pending);
    next_state.rx_vector = lowest_buffer(rx_pending);

    // Mirror of the protocol engine, reserved codes passed as given
    next_state.protocol_status = pack_status(fault_mode_field,
      slot_policy_field, poc_state_field, boot_substate_field,
      wake_outcome_field);

    // Write channel: address and data accepted in either order
    unique case (state.write_state)
      WRITE_COLLECT: begin
        if (s_axi_awvalid && !state.aw_held) begin
          next_state.aw_held = 1'b1;
          next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_held) begin
          next_state.w_held = 1'b1;
        end
        if (next_state.aw_held && next_state.w_held) begin
          // Data is dropped: every register here is read-only
          next_state.write_state = WRITE_ANSWER;
          next_state.bresp = is_mapped(next_state.aw_addr) ?
            RESP_OKAY : RESP_SLVERR;
        end
      end
      WRITE_ANSWER: begin
        if (s_axi_bready) begin
          next_state.write_state = WRITE_COLLECT;
          next_state.aw_held = 1'b0;
          next_state.w_held = 1'b0;
        end
      end
    endcase

    // Read channel: answer one cycle after the address is taken
    unique case (state.read_state)
      READ_IDLE: begin
        if (s_axi_arvalid) begin
          next_state.read_state = READ_ANSWER;
          next_state.rdata = AXI_DATA_WIDTH'(
            reg_value(s_axi_araddr, state, count_a, count_b));
          next_state.rresp = is_mapped(s_axi_araddr) ?
            RESP_OKAY : RESP_SLVERR;
        end
      end
      READ_ANSWER: begin
        if (s_axi_rready) begin
          next_state.read_state = READ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state.read_state <= READ_IDLE;
      state.write_state <= WRITE_COLLECT;
      state.aw_held <= 1'b0;
      state.w_held <= 1'b0;
      state.aw_addr <= '0;
      state.bresp <= RESP_OKAY;
      state.rdata <= '0;
      state.rresp <= RESP_OKAY;
      state.tx_vector <= VECTOR_RESET[TX_VEC_LSB +: VEC_WIDTH];
      state.rx_vector <= VECTOR_RESET[RX_VEC_LSB +: VEC_WIDTH];
      state.protocol_status <= PROTOCOL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign tx_vector_field = state.tx_vector;
  assign rx_vector_field = state.rx_vector;
  assign chan_a_error_count = count_a;
  assign chan_b_error_count = count_b;
  assign protocol_status_0 = state.protocol_status;
  assign engine_halted =
    (state.protocol_status[POC_LSB +: 3] == POC_HALT);

  assign s_axi_awready = (state.write_state == WRITE_COLLECT) &&
    !state.aw_held;
  assign s_axi_wready = (state.write_state == WRITE_COLLECT) &&
    !state.w_held;
  assign s_axi_bvalid = (state.write_state == WRITE_ANSWER);
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = (state.read_state == READ_IDLE);
  assign s_axi_rvalid = (state.read_state == READ_ANSWER);
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;

endmodule

// File: verilog/slot_error_counter.sv
`timescale 1ns/1ps
module slot_error_counter
  import msgbuf_status_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slot_end,
  input wire logic syntax_error,
  input wire logic content_error,
  input wire logic boundary_error,
  input wire logic tx_conflict,
  output logic [COUNT_WIDTH-1:0] count
);

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
  } counter_state_type;

  counter_state_type state;
  counter_state_type next_state;

  always_comb begin
    next_state = state;
    // One step per evaluated slot or segment with any error indicator
    if (slot_end && (syntax_error || content_error || boundary_error ||
        tx_conflict)) begin
      next_state.count = state.count + COUNT_WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state.count <= COUNT_WIDTH'(COUNT_RESET);
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;

endmodule
